// file: hdl/evt_timer.sv
/*
 * 8-bit timer / event counter with clear-on-match, square-wave and
 * PWM output, registers on AHB-Lite (zero wait state, always OKAY).
 * Assumes a 50 MHz clk; the event pin is asynchronous and is
 * synchronised before use.
 */
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`include "evt_defines.svh"
`default_nettype none

// Functional notes
// - Event mode counts each chosen pin edge
// - Clock select 00H falling, 01H rising edge
// - Outside PWM, match clears counter and pulses interrupt
// - Clock select bits 0-2 pick count clock
// - Square mode toggles output on match when bit 1 is set
// - Square period is 2(N+1) count clocks
// - Level bits preset output low or high
// - Mode bit 6 selects free-running PWM
// - Bit 1 selects PWM active polarity
// - PWM ignores level set and clear bits
// - PWM active from overflow until match
// - Stopping in PWM forces inactive output
// - PWM period 256, width N clocks
// - PWM compare writes buffered until overflow
// - Compare reads return newest written value
// - Bit 0 enables timer output pin
// - First match may come up to one count clock early
// - Enable clear stops and zeroes counter
// - Level bits always read as zero
module evt_timer
    import evt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        event_input_pin,
    output logic             timer_output_pin,
    output logic             match_interrupt_request
);

    // ****************************************
    // Bus slave
    // ****************************************
    logic       wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] mode_control_register;
    logic [2:0] count_clock_field;
    logic [7:0] compare_value_register;
    logic [7:0] compare_active_reg;
    logic       compare_pend_reg;
    logic       compare_late_reg;
    logic [7:0] event_counter_value;
    logic       match_seen_reg;
    logic       bus_wr;
    logic       mode_wr;
    logic       cmp_wr;
    logic       stat_wr;
    logic       addr_phase;

    assign addr_phase = hsel & hready & htrans[`EVT_HTRANS_NSEQ];
    assign bus_wr  = wr_pend_reg;
    assign mode_wr = bus_wr & (wr_addr_reg == `EVT_OFS_MODE);
    assign cmp_wr  = bus_wr & (wr_addr_reg == `EVT_OFS_COMPARE);
    assign stat_wr = bus_wr & (wr_addr_reg == `EVT_OFS_STATUS);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= `EVT_RESET_BYTE;
        end else begin
            wr_pend_reg <= addr_phase & hwrite;
            wr_addr_reg <= haddr;
        end
    end

    // Read data registered in the address phase; zero wait state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            case (haddr)
                `EVT_OFS_MODE:    hrdata <= {24'h0, mode_control_register & `EVT_MODE_RDMASK};
                `EVT_OFS_CLKSEL:  hrdata <= {29'h0, count_clock_field};
                `EVT_OFS_COMPARE: hrdata <= {24'h0, compare_value_register};
                `EVT_OFS_COUNTER: hrdata <= {24'h0, event_counter_value};
                `EVT_OFS_STATUS:  hrdata <= {31'h0, match_seen_reg};
                default:          hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_control_register <= `EVT_RESET_BYTE;
        end else if (mode_wr) begin
            mode_control_register <= hwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_clock_field <= `EVT_CS_PIN_FALL;
        end else if (bus_wr && wr_addr_reg == `EVT_OFS_CLKSEL) begin
            count_clock_field <= hwdata[2:0];
        end
    end

    logic count_enable_bit;
    logic pwm_mode_select_bit;
    logic active_level_bit;
    logic output_enable_bit;
    logic output_level_set_bit;
    logic output_level_clear_bit;

    assign count_enable_bit       = mode_control_register[`EVT_MODE_CE];
    assign pwm_mode_select_bit    = mode_control_register[`EVT_MODE_PWM];
    assign active_level_bit       = mode_control_register[`EVT_MODE_ALV];
    assign output_enable_bit      = mode_control_register[`EVT_MODE_OE];
    assign output_level_set_bit   = mode_control_register[`EVT_MODE_LVSET];
    assign output_level_clear_bit = mode_control_register[`EVT_MODE_LVCLR];

    // ****************************************
    // Count clock source
    // ****************************************
    logic                   pin_meta_reg;
    logic                   pin_sync_reg;
    logic                   pin_prev_reg;
    logic [`EVT_PRESC_W-1:0] presc_reg;
    logic [`EVT_PRESC_W-1:0] presc_next;
    logic                   tick;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= event_input_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Free-running prescaler: start is not aligned to it, so the first
    // period may run up to one count clock short
    assign presc_next = presc_reg + 1'b1;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_next;
        end
    end

    always_comb begin
        case (count_clock_field)
            `EVT_CS_PIN_FALL: tick = pin_prev_reg & ~pin_sync_reg;
            `EVT_CS_PIN_RISE: tick = ~pin_prev_reg & pin_sync_reg;
            `EVT_CS_DIV2:     tick = presc_next[0] & ~presc_reg[0];
            `EVT_CS_DIV4:     tick = presc_next[1] & ~presc_reg[1];
            `EVT_CS_DIV16:    tick = presc_next[3] & ~presc_reg[3];
            `EVT_CS_DIV64:    tick = presc_next[5] & ~presc_reg[5];
            `EVT_CS_DIV256:   tick = presc_next[7] & ~presc_reg[7];
            `EVT_CS_DIV1024:  tick = presc_next[9] & ~presc_reg[9];
            default:          tick = 1'b0;
        endcase
    end

    // ****************************************
    // Counter and compare
    // ****************************************
    logic run_tick;
    logic match_hit;
    logic overflow;

    assign run_tick  = count_enable_bit & tick;
    assign match_hit = run_tick & ~pwm_mode_select_bit
                     & (event_counter_value == compare_active_reg);
    assign overflow  = run_tick & pwm_mode_select_bit
                     & (event_counter_value == `EVT_CNT_TOP);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            event_counter_value <= `EVT_CNT_ZERO;
        end else if (!count_enable_bit) begin
            event_counter_value <= `EVT_CNT_ZERO;
        end else if (match_hit) begin
            event_counter_value <= `EVT_CNT_ZERO;
        end else if (run_tick) begin
            event_counter_value <= event_counter_value + 8'h01;
        end
    end

    // Software-visible copy; active copy follows it at once outside PWM
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            compare_value_register <= `EVT_RESET_BYTE;
        end else if (cmp_wr) begin
            compare_value_register <= hwdata[7:0];
        end
    end

    // A write landing once the counter stands at FFH misses the coming
    // overflow and moves on the one after it; earlier writes move on the next
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            compare_active_reg <= `EVT_RESET_BYTE;
            compare_pend_reg   <= 1'b0;
            compare_late_reg   <= 1'b0;
        end else if (!pwm_mode_select_bit || !count_enable_bit) begin
            compare_pend_reg <= 1'b0;
            compare_late_reg <= 1'b0;
            if (cmp_wr) begin
                compare_active_reg <= hwdata[7:0];
            end else begin
                compare_active_reg <= compare_value_register;
            end
        end else if (cmp_wr) begin
            compare_pend_reg <= 1'b1;
            compare_late_reg <= (event_counter_value == `EVT_CNT_TOP) & ~overflow;
        end else if (overflow && compare_late_reg) begin
            compare_late_reg <= 1'b0;
        end else if (overflow && compare_pend_reg) begin
            compare_active_reg <= compare_value_register;
            compare_pend_reg   <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            match_interrupt_request <= 1'b0;
        end else begin
            match_interrupt_request <= match_hit;
        end
    end

    // Sticky copy for polling; a new match wins over a clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            match_seen_reg <= 1'b0;
        end else if (match_hit) begin
            match_seen_reg <= 1'b1;
        end else if (stat_wr && hwdata[`EVT_STAT_MATCH]) begin
            match_seen_reg <= 1'b0;
        end
    end

    // ****************************************
    // Output flip-flop
    // ****************************************
    logic         toggle_ff_reg;
    logic         pwm_active_reg;
    evt_outmode_t out_mode;
    logic         pwm_level;
    logic [7:0]   compare_next;

    // Compare that governs the period the coming overflow opens
    assign compare_next = (compare_pend_reg && !compare_late_reg) ? compare_value_register
                                                                  : compare_active_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            toggle_ff_reg <= 1'b0;
        end else if (pwm_mode_select_bit || (mode_wr && hwdata[`EVT_MODE_PWM])) begin
            toggle_ff_reg <= toggle_ff_reg;
        end else if (mode_wr && hwdata[`EVT_MODE_LVCLR] && !hwdata[`EVT_MODE_LVSET]) begin
            toggle_ff_reg <= 1'b0;
        end else if (mode_wr && hwdata[`EVT_MODE_LVSET] && !hwdata[`EVT_MODE_LVCLR]) begin
            toggle_ff_reg <= 1'b1;
        end else if (match_hit && active_level_bit) begin
            toggle_ff_reg <= ~toggle_ff_reg;
        end
    end

    // Active from overflow until match of the active compare value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_active_reg <= 1'b0;
        end else if (!count_enable_bit || !pwm_mode_select_bit) begin
            pwm_active_reg <= 1'b0;
        end else if (overflow) begin
            pwm_active_reg <= compare_next != `EVT_CNT_ZERO;
        end else if (run_tick && event_counter_value + 8'h01 == compare_active_reg) begin
            pwm_active_reg <= 1'b0;
        end
    end

    always_comb begin
        if (!output_enable_bit) begin
            out_mode = EVT_OUT_OFF;
        end else if (pwm_mode_select_bit) begin
            out_mode = EVT_OUT_PWM;
        end else begin
            out_mode = EVT_OUT_SQUARE;
        end
    end

    assign pwm_level = pwm_active_reg ^ active_level_bit;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_output_pin <= 1'b0;
        end else begin
            case (out_mode)
                EVT_OUT_OFF:    timer_output_pin <= 1'b0;
                EVT_OUT_SQUARE: timer_output_pin <= toggle_ff_reg;
                EVT_OUT_PWM:    timer_output_pin <= pwm_level;
                default:        timer_output_pin <= 1'b0;
            endcase
        end
    end

endmodule : evt_timer

`default_nettype wire

// file: hdl/evt_defines.svh
/*
 * Constants for the 8-bit event timer / PWM block: register offsets,
 * field positions, reset values and count clock selections.
 * Assumes it is included by bare name from design files.
 */
`ifndef EVT_DEFINES_SVH
`define EVT_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define EVT_OFS_MODE     8'h00
`define EVT_OFS_CLKSEL   8'h04
`define EVT_OFS_COMPARE  8'h08
`define EVT_OFS_COUNTER  8'h0C
`define EVT_OFS_STATUS   8'h10

// ****************************************
// Mode control field positions
// ****************************************
`define EVT_MODE_OE      0
`define EVT_MODE_ALV     1
`define EVT_MODE_LVCLR   2
`define EVT_MODE_LVSET   3
`define EVT_MODE_PWM     6
`define EVT_MODE_CE      7
`define EVT_MODE_RDMASK  8'hC3

// ****************************************
// Clock select codes
// ****************************************
`define EVT_CS_PIN_FALL  3'h0
`define EVT_CS_PIN_RISE  3'h1
`define EVT_CS_DIV2      3'h2
`define EVT_CS_DIV4      3'h3
`define EVT_CS_DIV16     3'h4
`define EVT_CS_DIV64     3'h5
`define EVT_CS_DIV256    3'h6
`define EVT_CS_DIV1024   3'h7

// ****************************************
// Misc values
// ****************************************
`define EVT_CNT_ZERO     8'h00
`define EVT_CNT_TOP      8'hFF
`define EVT_RESET_BYTE   8'h00
`define EVT_PRESC_W      10
`define EVT_HTRANS_NSEQ  1
`define EVT_STAT_MATCH   0

`endif

// file: hdl/evt_pkg.sv
/*
 * Types shared by the event timer design.
 * Assumes evt_defines.svh supplies the numeric constants.
 */
`default_nettype none

package evt_pkg;
    typedef enum logic [1:0] {
        EVT_OUT_OFF,
        EVT_OUT_SQUARE,
        EVT_OUT_PWM
    } evt_outmode_t;
endpackage : evt_pkg

`default_nettype wire

// file: test/evt_partner.sv
/* External pulse source for the event input of evt_timer.
   Assumes the bench calls toggle() from its main sequence. */
`default_nettype none

module evt_partner (
    input  wire logic clk,
    output var logic  event_input_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****
    // Pulse source
    // ****
    initial event_input_pin = 1'b0;

    // Pin only ever feeds an input; level holds between bursts
    task automatic toggle(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge clk);
            event_input_pin <= ~event_input_pin;
        end
    endtask : toggle
endmodule : evt_partner

`default_nettype wire

// file: test/evt_timer_monitor.sv
/* Port checker for evt_timer, bound to every instance.
   Assumes the one slave drives hready through hreadyout. */
`include "evt_defines.svh"
`default_nettype none

module evt_timer_monitor (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        event_input_pin,
    input wire logic        timer_output_pin,
    input wire logic        match_interrupt_request
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****
    // Shadow of bus traffic
    // ****
    logic       dwr_reg;
    logic       drd_reg;
    logic [7:0] da_reg;
    logic [7:0] mode_reg;
    logic [7:0] cmp_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dwr_reg <= 1'b0;
            drd_reg <= 1'b0;
            da_reg  <= 8'h00;
        end else if (hready) begin
            dwr_reg <= hsel && htrans[1] && hwrite;
            drd_reg <= hsel && htrans[1] && !hwrite;
            da_reg  <= haddr;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg <= 8'h00;
        end else if (dwr_reg && da_reg == `EVT_OFS_MODE) begin
            mode_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_reg <= 8'h00;
        end else if (dwr_reg && da_reg == `EVT_OFS_COMPARE) begin
            cmp_reg <= hwdata[7:0];
        end
    end

    // ****
    // Properties
    // ****
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_irq_pulse;
        match_interrupt_request |=> !match_interrupt_request;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("match pulse too long");

    property p_oe_off;
        (!mode_reg[0]) [*4] |-> !timer_output_pin;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin high while disabled");

    property p_level;
        dwr_reg && da_reg == `EVT_OFS_MODE && hwdata[0] && hwdata[7:6] == 2'h0
            && (hwdata[3] ^ hwdata[2]) |-> ##[1:3] timer_output_pin == mode_reg[3];
    endproperty
    a_level: assert property (p_level) else $error("preset level missing");

    property p_rd_mode;
        drd_reg && da_reg == `EVT_OFS_MODE
            |-> hrdata == {24'h0, $past(mode_reg) & `EVT_MODE_RDMASK};
    endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("mode readback wrong");

    property p_rd_cmp;
        drd_reg && da_reg == `EVT_OFS_COMPARE |-> hrdata == {24'h0, $past(cmp_reg)};
    endproperty
    a_rd_cmp: assert property (p_rd_cmp) else $error("compare readback wrong");

    property p_pwm_stop;
        (mode_reg[6] && mode_reg[0] && !mode_reg[7]) [*4]
            |-> timer_output_pin == $past(mode_reg[1]);
    endproperty
    a_pwm_stop: assert property (p_pwm_stop) else $error("stopped pwm not inactive");

    property p_cnt_clr;
        drd_reg && da_reg == `EVT_OFS_COUNTER && !$past(mode_reg[7])
            && !$past(mode_reg[7], 2) |-> hrdata == 32'h0;
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("stopped counter not zero");

    property p_unmapped;
        drd_reg && da_reg > `EVT_OFS_STATUS |-> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_bus_ok;
        hsel && htrans[1] |-> hreadyout && !hresp;
    endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");

    c_irq: cover property (match_interrupt_request);
    c_pwm: cover property (mode_reg[6] && mode_reg[7] && $rose(timer_output_pin));
    c_cmp: cover property (drd_reg && da_reg == `EVT_OFS_COMPARE);
endmodule : evt_timer_monitor

bind evt_timer evt_timer_monitor u_mon (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .event_input_pin(event_input_pin),
    .timer_output_pin(timer_output_pin), .match_interrupt_request(match_interrupt_request)
);

`default_nettype wire

// file: test/evt_timer_bench.sv
/* Self-checking bench for evt_timer: event rows, then reset, square
   and PWM cases. Assumes evt_partner supplies the event pin. */
`include "evt_defines.svh"
`default_nettype none

module evt_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        logic [31:0] cs;
        logic [31:0] cmp;
        int          n;
        int          half;
        logic [31:0] cnt;
        logic [31:0] irq;
    } evt_row_t;

    logic        clk       = 1'b0;
    logic        reset_n   = 1'b0;
    logic        hsel      = 1'b0;
    logic [7:0]  haddr     = 8'h00;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin_in;
    logic        timer_output_pin;
    logic        match_interrupt_request;
    logic [31:0] rd;
    longint      t0;
    int          err_count    = 0;
    int          total_checks = 0;
    int          irq_n        = 0;
    // Odd toggle counts alternate the idle level, so edge choice matters
    evt_row_t    rows [4] = '{
        '{32'h1, 32'h5, 7, 2, 32'h4, 32'h0},
        '{32'h0, 32'h2, 7, 7, 32'h1, 32'h1},
        '{32'h1, 32'h0, 5, 3, 32'h0, 32'h3},
        '{32'h0, 32'hFF, 9, 2, 32'h5, 32'h0}
    };

    evt_timer dut (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .event_input_pin(pin_in),
        .timer_output_pin(timer_output_pin), .match_interrupt_request(match_interrupt_request)
    );
    evt_partner u_src (.clk(clk), .event_input_pin(pin_in));

    // ****
    // Helpers
    // ****
    initial begin
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (match_interrupt_request === 1'b1) irq_n <= irq_n + 1;
    end

    task automatic tally_and_finish;
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= we;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic wait_pin(input logic v);
        while (timer_output_pin !== v) @(negedge clk);
    endtask : wait_pin

    task automatic pin_is(input logic v);
        repeat (4) @(negedge clk);
        chk({31'h0, timer_output_pin}, {31'h0, v});
    endtask : pin_is

    function automatic logic [31:0] span(input longint t);
        return 32'(($time - t) / 20);
    endfunction : span

    // ****
    // Sequence
    // ****
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, `EVT_OFS_MODE, 32'h0);
            xfer(1'b1, `EVT_OFS_CLKSEL, rows[i].cs);
            xfer(1'b1, `EVT_OFS_COMPARE, rows[i].cmp);
            irq_n = 0;
            xfer(1'b1, `EVT_OFS_MODE, 32'h80);
            u_src.toggle(rows[i].n, rows[i].half);
            repeat (8) @(posedge clk);
            xfer(1'b0, `EVT_OFS_COUNTER, 32'h0);
            chk(rd, rows[i].cnt);
            chk(32'(irq_n), rows[i].irq);
        end
        xfer(1'b0, `EVT_OFS_STATUS, 32'h0);
        chk(rd, 32'h1);
        xfer(1'b1, `EVT_OFS_STATUS, 32'h1);
        xfer(1'b0, `EVT_OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int a = 0; a <= 'h14; a += 4) begin
            xfer(1'b0, 8'(a), 32'h0);
            chk(rd, 32'h0);
        end
        xfer(1'b1, `EVT_OFS_MODE, 32'h9);
        pin_is(1'b1);
        xfer(1'b0, `EVT_OFS_MODE, 32'h0);
        chk(rd, 32'h1);
        xfer(1'b1, `EVT_OFS_MODE, 32'hA);
        pin_is(1'b0);
        xfer(1'b1, `EVT_OFS_CLKSEL, 32'h2);
        xfer(1'b1, `EVT_OFS_COMPARE, 32'h3);
        xfer(1'b1, `EVT_OFS_MODE, 32'hB);
        pin_is(1'b1);
        xfer(1'b1, `EVT_OFS_MODE, 32'h83);
        wait_pin(1'b0);
        t0 = $time;
        wait_pin(1'b1);
        chk(span(t0), 32'h8);
        t0 = $time;
        wait_pin(1'b0);
        chk(span(t0), 32'h8);
        xfer(1'b1, `EVT_OFS_MODE, 32'h3);
        xfer(1'b1, `EVT_OFS_MODE, 32'h7);
        pin_is(1'b0);
        xfer(1'b1, `EVT_OFS_MODE, 32'h0);
        xfer(1'b1, `EVT_OFS_COMPARE, 32'h40);
        xfer(1'b1, `EVT_OFS_MODE, 32'h41);
        xfer(1'b1, `EVT_OFS_MODE, 32'hC1);
        wait_pin(1'b1);
        t0 = $time;
        wait_pin(1'b0);
        chk(span(t0), 32'h80);
        wait_pin(1'b1);
        chk(span(t0), 32'h200);
        t0 = $time;
        xfer(1'b1, `EVT_OFS_COMPARE, 32'h20);
        xfer(1'b0, `EVT_OFS_COMPARE, 32'h0);
        chk(rd, 32'h20);
        wait_pin(1'b0);
        chk(span(t0), 32'h80);
        wait_pin(1'b1);
        t0 = $time;
        wait_pin(1'b0);
        chk(span(t0), 32'h40);
        wait_pin(1'b1);
        xfer(1'b1, `EVT_OFS_MODE, 32'h41);
        pin_is(1'b0);
        xfer(1'b1, `EVT_OFS_MODE, 32'h43);
        pin_is(1'b1);
        xfer(1'b1, `EVT_OFS_CLKSEL, 32'h3);
        xfer(1'b1, `EVT_OFS_MODE, 32'hC3);
        wait_pin(1'b0);
        t0 = $time;
        wait_pin(1'b1);
        chk(span(t0), 32'h80);
        tally_and_finish;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish;
    end
endmodule : evt_timer_bench

`default_nettype wire
